// File: include/qbp_pkg.sv
// package of constants for the quasi-bidirectional port three
package qbp_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    // ------------------------------------------------------------
    // pin positions of the alternate functions
    // ------------------------------------------------------------
    localparam int BIT_SER_RX = 0;
    localparam int BIT_SER_TX = 1;
    localparam int BIT_IRQ0 = 2;
    localparam int BIT_IRQ1 = 3;
    localparam int BIT_CNT0 = 4;
    localparam int BIT_CNT1 = 5;
    localparam int BIT_WR = 6;
    localparam int BIT_RD = 7;
    // ------------------------------------------------------------
    // timing of the momentary strong pull-high
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BOOST_TIME_NS = 50;
    localparam int BOOST_CYCLES_RAW = BOOST_TIME_NS / CLK_PERIOD_NS;
    localparam int BOOST_CYCLES = (BOOST_CYCLES_RAW < 1) ? 1 :
        BOOST_CYCLES_RAW;
    localparam int BOOST_CNT_W = 4;
    localparam logic [3:0] BOOST_LOAD = 4'(BOOST_CYCLES);
    localparam logic [3:0] BOOST_IDLE = 4'h0;
endpackage : qbp_pkg

// File: rtl/qbp_pin_cell.sv
// one pin cell: strong pulldown, momentary boost and weak pullup
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_cell
    import qbp_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // drive request from the combined latch and alternate output
    input wire logic drive_level_in,
    // pad controls
    output logic pull_low_oe_out,
    output logic boost_oe_out,
    output logic weak_pullup_out
);
    logic prev_level;
    logic [3:0] boost_cnt;
    logic next_prev_level;
    logic [3:0] next_boost_cnt;
    logic next_pull_low;
    logic next_boost;
    logic next_weak;

    // ------------------------------------------------------------
    // next values of the pad controls
    // ------------------------------------------------------------
    always_comb begin
        next_prev_level = drive_level_in;
        next_boost_cnt = boost_cnt;
        if (drive_level_in && !prev_level) begin
            next_boost_cnt = BOOST_LOAD; // zero to one starts boost
        end else if (!drive_level_in) begin
            next_boost_cnt = BOOST_IDLE;
        end else if (boost_cnt != BOOST_IDLE) begin
            next_boost_cnt = boost_cnt - 4'h1;
        end
        next_pull_low = !drive_level_in; // strong pulldown on zero
        next_boost = next_boost_cnt != BOOST_IDLE;
        // only the weak pullup holds a steady one
        next_weak = drive_level_in && (next_boost_cnt == BOOST_IDLE);
    end

    // ------------------------------------------------------------
    // registers; reset holds the pin as a weak-pulled one
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_level <= 1'b1;
            boost_cnt <= BOOST_IDLE;
            pull_low_oe_out <= 1'b0;
            boost_oe_out <= 1'b0;
            weak_pullup_out <= 1'b1;
        end else begin
            prev_level <= next_prev_level;
            boost_cnt <= next_boost_cnt;
            pull_low_oe_out <= next_pull_low;
            boost_oe_out <= next_boost;
            weak_pullup_out <= next_weak;
        end
    end
endmodule : qbp_pin_cell
`default_nettype wire

// File: rtl/qbp_port3.sv
// eight-pin quasi-bidirectional port with alternate functions
// Contract
// - eight independent pins, each general I/O and one alternate function
// - reset sets every port latch bit to one
// - a steady one is held by the weak pullup only
// - a weak-pulled pin is an input; outside may pull it low
// - writing zero turns on the strong pulldown until one or reset
// - a zero-to-one change briefly enables a strong pull-high driver
// - after the boost the pin is both output high and input
// - bit 0 serial receive input, bit 1 serial transmit output
// - bits 2 and 3 carry external interrupt 0 and 1 inputs
// - bits 4 and 5 carry timer 0 and 1 count inputs
// - bit 6 write strobe, bit 7 read strobe, both active low
`timescale 1ns/1ps
`default_nettype none
module qbp_port3
    import qbp_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // core side latch write
    input wire logic latch_we_in,
    input wire logic [7:0] latch_wdata_in,
    // serial transmit output from the core
    input wire logic serial0_transmit_in,
    // external memory strobes from the core, active low
    input wire logic ext_wr_n_in,
    input wire logic ext_rd_n_in,
    // pin inputs from the pads
    input wire logic [7:0] pin_in,
    // pad controls: strong pulldown enables
    output logic [7:0] pin_pull_low_oe_out,
    // pad controls: momentary strong pull-high enables
    output logic [7:0] pin_boost_oe_out,
    // pad controls: weak pullup enables
    output logic [7:0] pin_weak_pullup_out,
    // core side readback of the latch
    output logic [7:0] latch_out,
    // core side sensed pad levels
    output logic [7:0] pin_level_out,
    // serial receive input to the core
    output logic serial0_receive_input_out,
    // external interrupt request inputs to the core
    output logic ext_irq_zero_input_out,
    output logic ext_irq_one_input_out,
    // timer count inputs to the core
    output logic counter_zero_count_input_out,
    output logic counter_one_count_input_out
);
    // port latch and its next value
    logic [7:0] port_latch;
    logic [7:0] next_port_latch;
    // synchroniser stages and their next values
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] next_sync_a;
    logic [7:0] next_sync_b;
    // level asked of each pad
    logic [7:0] alt_out;
    logic [7:0] drive_level;
    // next values of the registered outputs
    logic [4:0] next_alt_in;
    logic [7:0] next_latch_out;
    logic [7:0] next_level;
    logic next_serial_rx;
    logic next_irq_zero;
    logic next_irq_one;
    logic next_count_zero;
    logic next_count_one;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // value of the latch after this edge; a write replaces all bits
    function automatic logic [7:0] write_latch(
        input logic [7:0] cur,
        input logic we,
        input logic [7:0] data
    );
        logic [7:0] result;
        result = cur;
        if (we) begin
            result = data; // software write
        end
        return result;
    endfunction : write_latch

    // places the alternate outputs on their pins; ones elsewhere
    // leave the latch alone, so an idle function has no effect
    function automatic logic [7:0] alt_mask(
        input logic tx,
        input logic wr_n,
        input logic rd_n
    );
        logic [7:0] mask;
        mask = 8'hFF;
        mask[BIT_SER_TX] = tx; // transmit
        mask[BIT_WR] = wr_n; // write strobe
        mask[BIT_RD] = rd_n; // read strobe
        return mask;
    endfunction : alt_mask

    // picks the sensed pins that feed the core peripherals,
    // packed as count one, count zero, irq one, irq zero, receive
    function automatic logic [4:0] alt_inputs(
        input logic [7:0] level
    );
        logic [4:0] picked;
        picked[0] = level[BIT_SER_RX]; // receive
        picked[1] = level[BIT_IRQ0]; // interrupt zero
        picked[2] = level[BIT_IRQ1]; // interrupt one
        picked[3] = level[BIT_CNT0]; // count zero
        picked[4] = level[BIT_CNT1]; // count one
        return picked;
    endfunction : alt_inputs

    // ------------------------------------------------------------
    // port latch
    // ------------------------------------------------------------
    // next latch value; writes may follow back to back
    always_comb begin
        next_port_latch = write_latch(port_latch, latch_we_in,
            latch_wdata_in);
    end

    // the latch itself; a write lands at this edge and the pad
    // controls follow one edge later
    // reset leaves every pin a weak-pulled one
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            port_latch <= LATCH_RESET; // all ones on reset
        end else begin
            port_latch <= next_port_latch;
        end
    end

    // ------------------------------------------------------------
    // alternate outputs combined with the latch
    // ------------------------------------------------------------
    // a pin goes low if the latch or its function asks for low;
    // software keeps the latch bit at one while a function drives
    // the pin, else the function cannot raise it
    always_comb begin
        alt_out = alt_mask(serial0_transmit_in, ext_wr_n_in, ext_rd_n_in);
        drive_level = port_latch & alt_out; // low if either low
    end

    // ------------------------------------------------------------
    // one cell per pin
    // ------------------------------------------------------------
    // each cell keeps its own boost count, so a write that raises
    // several pins boosts all of them in the same cycles
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
        qbp_pin_cell u_cell ( // independent pins
            .core_clk_in(core_clk_in),
            .sys_rst_in(sys_rst_in),
            .drive_level_in(drive_level[i]),
            .pull_low_oe_out(pin_pull_low_oe_out[i]),
            .boost_oe_out(pin_boost_oe_out[i]),
            .weak_pullup_out(pin_weak_pullup_out[i])
        );
    end

    // ------------------------------------------------------------
    // pin sensing through two flip-flops
    // ------------------------------------------------------------
    // the pads move with no regard to the clock; the first stage may
    // settle late, so nothing but the second stage reads it
    always_comb begin
        next_sync_a = pin_in;
        next_sync_b = sync_a;
    end

    // synchroniser stages, reset to the weak-pulled idle level
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync_a <= 8'hFF;
            sync_b <= 8'hFF;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ------------------------------------------------------------
    // readback and alternate inputs to the core
    // ------------------------------------------------------------
    // the readback shows the latch as it stands after this edge,
    // so software sees its own write at once
    always_comb begin
        next_latch_out = next_port_latch;
        next_level = sync_b; // sensed level
        next_alt_in = alt_inputs(sync_b);
        next_serial_rx = next_alt_in[0];
        next_irq_zero = next_alt_in[1];
        next_irq_one = next_alt_in[2];
        next_count_zero = next_alt_in[3];
        next_count_one = next_alt_in[4];
    end

    // every output comes straight from a flip-flop; reset shows
    // the idle level of a weak-pulled pad
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            latch_out <= LATCH_RESET;
            pin_level_out <= 8'hFF;
            serial0_receive_input_out <= 1'b1;
            ext_irq_zero_input_out <= 1'b1;
            ext_irq_one_input_out <= 1'b1;
            counter_zero_count_input_out <= 1'b1;
            counter_one_count_input_out <= 1'b1;
        end else begin
            latch_out <= next_latch_out;
            pin_level_out <= next_level;
            serial0_receive_input_out <= next_serial_rx;
            ext_irq_zero_input_out <= next_irq_zero;
            ext_irq_one_input_out <= next_irq_one;
            counter_zero_count_input_out <= next_count_zero;
            counter_one_count_input_out <= next_count_one;
        end
    end
endmodule : qbp_port3
`default_nettype wire

// File: testbench/qbp_board.sv
// board model: outside pulls and the resolved level of each pad
`timescale 1ns/1ps
`default_nettype none
module qbp_board (
    input wire logic [7:0] pull_low_in, boost_in, weak_in, ext_low_in,
    output logic [7:0] pin_out
);
    // pulldown or an outside low overpowers the pullups
    // an undriven pad reads low here
    assign pin_out = ~pull_low_in & ~ext_low_in & (boost_in | weak_in);
endmodule : qbp_board
`default_nettype wire

// File: testbench/qbp_port3_assertions.sv
// checker of the pad control timing of port three
`timescale 1ns/1ps
`default_nettype none
module qbp_port3_chk
    import qbp_pkg::*;
(
    input wire logic core_clk_in, sys_rst_in, latch_we_in, ext_wr_n_in,
    input wire logic serial0_transmit_in, ext_rd_n_in,
    input wire logic serial0_receive_input_out, ext_irq_zero_input_out,
    input wire logic ext_irq_one_input_out, counter_zero_count_input_out,
    input wire logic counter_one_count_input_out,
    input wire logic [7:0] latch_wdata_in, pin_in, pin_pull_low_oe_out,
    input wire logic [7:0] pin_boost_oe_out, pin_weak_pullup_out, latch_out,
    input wire logic [7:0] pin_level_out
);
    logic [7:0] drv;
    logic [7:0] wp;
    // level asked for: latch combined with the alternate outputs
    assign drv = latch_out & {ext_rd_n_in, ext_wr_n_in, 4'hF,
        serial0_transmit_in, 1'b1};
    assign wp = pin_weak_pullup_out;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_pull; pin_pull_low_oe_out == ~$past(drv); endproperty
    property p_wr; latch_we_in |=> latch_out == $past(latch_wdata_in);
    endproperty
    property p_hold; !latch_we_in |=> $stable(latch_out); endproperty
    property p_boost; $rose(latch_out[0]) |=> pin_boost_oe_out[0] [*2]
        ##1 (!pin_boost_oe_out[0] && wp[0]); endproperty
    property p_one; ((wp & (pin_pull_low_oe_out | pin_boost_oe_out))
        | (pin_pull_low_oe_out & pin_boost_oe_out)) == 8'h00; endproperty
    property p_sync; pin_level_out == $past(pin_in, 3); endproperty
    property p_alt; {counter_one_count_input_out, counter_zero_count_input_out,
        ext_irq_one_input_out, ext_irq_zero_input_out,
        serial0_receive_input_out} == {$past(pin_in[5:2], 3),
        $past(pin_in[0], 3)}; endproperty
    property p_rst; $fell(sys_rst_in) |-> latch_out == LATCH_RESET
        && wp == 8'hFF; endproperty
    a_pull: assert property (p_pull) else $error("pulldown wrong");
    a_wr: assert property (p_wr) else $error("latch not written");
    a_hold: assert property (p_hold) else $error("latch moved");
    a_boost: assert property (p_boost) else $error("boost wrong");
    a_one: assert property (p_one) else $error("drivers overlap");
    a_sync: assert property (p_sync) else $error("level wrong");
    a_alt: assert property (p_alt) else $error("alt input wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_boost: cover property ($rose(pin_boost_oe_out[0]));
    c_pull: cover property (pin_pull_low_oe_out == 8'hFF);
    c_ext: cover property ($fell(pin_level_out[2]));
endmodule : qbp_port3_chk
bind qbp_port3 qbp_port3_chk u_chk (.*);
`default_nettype wire

// File: testbench/qbp_port3_bench.sv
// self-checking bench of the quasi-bidirectional port three
`timescale 1ns/1ps
`default_nettype none
module qbp_port3_bench;
    logic core_clk_in = 0, sys_rst_in = 1, latch_we_in = 0;
    logic serial0_transmit_in = 1, ext_wr_n_in = 1, ext_rd_n_in = 1;
    logic [7:0] latch_wdata_in = 8'hFF, ext_low = 8'h00, pin_in;
    logic [7:0] pin_pull_low_oe_out, pin_boost_oe_out, pin_weak_pullup_out;
    logic [7:0] latch_out, pin_level_out;
    logic serial0_receive_input_out, ext_irq_zero_input_out;
    logic ext_irq_one_input_out, counter_zero_count_input_out;
    logic counter_one_count_input_out;
    int miscompares = 0, samples_checked = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    qbp_port3 dut (.*);
    qbp_board board (.pull_low_in(pin_pull_low_oe_out), .ext_low_in(ext_low),
        .boost_in(pin_boost_oe_out), .weak_in(pin_weak_pullup_out),
        .pin_out(pin_in));
    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : tick
    task automatic wr(input logic [7:0] v);
        latch_we_in = 1;
        latch_wdata_in = v;
        tick(1);
        latch_we_in = 0;
    endtask : wr
    task automatic t_reset;
        chk("latch", latch_out, 8'hFF);
        chk("weak", pin_weak_pullup_out, 8'hFF);
        chk("boost", pin_boost_oe_out, 8'h00);
        chk("level", pin_level_out, 8'hFF);
    endtask : t_reset
    task automatic t_write;
        wr(8'h00);
        wr(8'hA5);
        chk("latch", latch_out, 8'hA5);
        chk("pull", pin_pull_low_oe_out, 8'hFF);
        tick(1);
        chk("pull", pin_pull_low_oe_out, 8'h5A);
        chk("boost", pin_boost_oe_out, 8'hA5);
        tick(1);
        chk("boost", pin_boost_oe_out, 8'hA5);
        tick(1);
        chk("boost", pin_boost_oe_out, 8'h00);
        chk("weak", pin_weak_pullup_out, 8'hA5);
        tick(1);
        chk("level", pin_level_out, 8'hA5);
        wr(8'hFF);
        tick(4);
    endtask : t_write
    task automatic t_input;
        ext_low = 8'h3D;
        tick(4);
        chk("level", pin_level_out, 8'hC2);
        chk("pull", pin_pull_low_oe_out, 8'h00);
        chk("alt", {3'h0, counter_one_count_input_out,
            counter_zero_count_input_out, ext_irq_one_input_out,
            ext_irq_zero_input_out, serial0_receive_input_out}, 8'h00);
        ext_low = 8'h00;
        tick(4);
        chk("alt", {3'h0, counter_one_count_input_out,
            counter_zero_count_input_out, ext_irq_one_input_out,
            ext_irq_zero_input_out, serial0_receive_input_out}, 8'h1F);
    endtask : t_input
    task automatic t_alt_out;
        {ext_rd_n_in, ext_wr_n_in, serial0_transmit_in} = 3'h0;
        tick(2);
        chk("pull", pin_pull_low_oe_out, 8'hC2);
        tick(2);
        chk("level", pin_level_out, 8'h3D);
        {ext_rd_n_in, ext_wr_n_in, serial0_transmit_in} = 3'h7;
        tick(5);
    endtask : t_alt_out
    task automatic t_midreset;
        wr(8'h00);
        sys_rst_in = 1;
        tick(1);
        chk("latch", latch_out, 8'hFF);
        chk("pull", pin_pull_low_oe_out, 8'h00);
        tick(4);
        sys_rst_in = 0;
        tick(1);
    endtask : t_midreset
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        tick(5);
        sys_rst_in = 0;
        tick(1);
        t_reset();
        t_write();
        t_input();
        t_alt_out();
        t_midreset();
        t_reset();
        print_verdict();
    end
endmodule : qbp_port3_bench
`default_nettype wire
